/* File: verilog/serdes_ctrl_pkg.sv */
// Shared constants, field layout and types for the channel control registers
`default_nettype none
package serdes_ctrl_pkg;

  // Register offsets on the management interface
  localparam logic [4:0]  ADDR_CH_CTRL = 5'h01;
  localparam logic [4:0]  ADDR_PLL     = 5'h02;
  localparam logic [4:0]  ADDR_TXRX    = 5'h03;

  // Reset values
  localparam logic [15:0] RST_CH_CTRL  = 16'h0300;
  localparam logic [15:0] RST_PLL      = 16'h811D;
  localparam logic [15:0] RST_TXRX     = 16'hA444;

  // Channel control word fields
  localparam int PD_BIT       = 15;
  localparam int RX_ONE_BIT   = 13;
  localparam int TX_ONE_BIT   = 12;
  localparam int HYST_LO      = 10;
  localparam int RX_SPLIT_BIT = 9;
  localparam int TX_MERGE_BIT = 8;
  localparam int DIV_LO       = 4;
  localparam int CLK_SRC_LO   = 2;
  localparam int REF_BIT      = 1;

  // PLL control word fields
  localparam int BW_LO        = 8;
  localparam int VCO_BIT      = 6;
  localparam int PLL_EN_BIT   = 4;
  localparam int MULT_LO      = 0;

  // Transmit and receive control word fields
  localparam int SWING_LO     = 12;
  localparam int TX_EN_BIT    = 10;
  localparam int RATE_LO      = 8;

  // Sync-loss hysteresis codes
  localparam logic [1:0] HYST_STD   = 2'h0;
  localparam logic [1:0] HYST_ONE   = 2'h1;
  localparam logic [1:0] HYST_TWO   = 2'h2;

  // Management frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HDR_LAST     = 4'hC;
  localparam logic [4:0] DATA_LAST    = 5'h11;
  localparam logic [4:0] TA_DONE      = 5'h01;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;

  typedef enum logic [1:0] {
    LANES_ONE  = 2'b00,
    LANES_TWO  = 2'b01,
    LANES_FOUR = 2'b10
  } lane_mode_t;

  typedef enum logic [1:0] {
    MD_PREAMBLE = 2'b00,
    MD_HEADER   = 2'b01,
    MD_DATA     = 2'b10
  } mdio_state_t;

  // Output clock divide factor, zero for reserved codes
  function automatic logic [4:0] divider_factor(input logic [3:0] code);
    unique case (code)
      4'h0:    divider_factor = 5'h01;
      4'h4:    divider_factor = 5'h02;
      4'h8:    divider_factor = 5'h04;
      4'h9:    divider_factor = 5'h08;
      4'hA:    divider_factor = 5'h10;
      4'hC:    divider_factor = 5'h05;
      4'hD:    divider_factor = 5'h0A;
      4'hE:    divider_factor = 5'h14;
      4'hF:    divider_factor = 5'h19;
      default: divider_factor = 5'h00;
    endcase
  endfunction : divider_factor

  // PLL multiplier in quarter steps, zero for reserved codes
  function automatic logic [6:0] mult_quarters(input logic [3:0] code);
    unique case (code)
      4'h2:    mult_quarters = 7'h10;
      4'h3:    mult_quarters = 7'h14;
      4'h4:    mult_quarters = 7'h18;
      4'h5:    mult_quarters = 7'h20;
      4'h6:    mult_quarters = 7'h21;
      4'h7:    mult_quarters = 7'h28;
      4'h8:    mult_quarters = 7'h30;
      4'h9:    mult_quarters = 7'h32;
      4'hA:    mult_quarters = 7'h3C;
      4'hB:    mult_quarters = 7'h40;
      4'hC:    mult_quarters = 7'h42;
      4'hD:    mult_quarters = 7'h50;
      4'hE:    mult_quarters = 7'h64;
      default: mult_quarters = 7'h00;
    endcase
  endfunction : mult_quarters

endpackage : serdes_ctrl_pkg
`default_nettype wire

/* File: verilog/channel_regs.sv */
// One channel's control registers, field decode and sync-loss error counter
`timescale 1ns/1ps
`default_nettype none
module channel_regs
  import serdes_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_b_in,
  // Register write and read port
  input  wire logic                      wr_en_in,
  input  wire logic [4:0]                wr_addr_in,
  input  wire logic [15:0]               wr_data_in,
  input  wire logic [4:0]                rd_addr_in,
  output logic      [15:0]               rd_data_out,
  // Synchronised pins
  input  wire logic                      datapath_bit_a_pin_b_in,
  input  wire logic                      ref_pin_in,
  // Receive decoder events
  input  wire logic                      char_valid_in,
  input  wire logic                      code_err_in,
  // Datapath controls
  output logic                           datapath_pd_out,
  output logic                           pll_run_out,
  output logic                           tx_run_out,
  output serdes_ctrl_pkg::lane_mode_t    rx_lane_mode_out,
  output serdes_ctrl_pkg::lane_mode_t    tx_lane_mode_out,
  output logic      [4:0]                clk_divide_out,
  output logic      [1:0]                clk_source_out,
  output logic                           ref_use_one_out,
  output logic      [1:0]                bandwidth_out,
  output logic                           vco_low_out,
  output logic      [6:0]                mult_quarters_out,
  output logic      [3:0]                tx_amplitude_out,
  output logic      [1:0]                tx_rate_out,
  output logic                           std_hysteresis_out,
  output logic                           force_unsync_out
);
  import serdes_ctrl_pkg::*;

  logic [15:0] ctrl_reg;
  logic [15:0] pll_reg;
  logic [15:0] txrx_reg;
  logic [1:0]  err_run_reg;
  logic [1:0]  err_run_next;
  logic [1:0]  hyst;
  logic        pd_any;

  assign hyst   = ctrl_reg[HYST_LO +: 2];
  assign pd_any = !datapath_bit_a_pin_b_in || ctrl_reg[PD_BIT];

  // Register storage, full width kept so reads return what was written
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_reg <= RST_CH_CTRL;
      pll_reg  <= RST_PLL;
      txrx_reg <= RST_TXRX;
    end
    else if (wr_en_in)
    begin
      if (wr_addr_in == ADDR_CH_CTRL) ctrl_reg <= wr_data_in;
      if (wr_addr_in == ADDR_PLL)     pll_reg  <= wr_data_in;
      if (wr_addr_in == ADDR_TXRX)    txrx_reg <= wr_data_in;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb
  begin
    unique case (rd_addr_in)
      ADDR_CH_CTRL: rd_data_out = ctrl_reg;
      ADDR_PLL:     rd_data_out = pll_reg;
      ADDR_TXRX:    rd_data_out = txrx_reg;
      default:      rd_data_out = 16'h0000;
    endcase
  end

  // Registered field decode towards the analog datapath
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      datapath_pd_out   <= 1'b0;
      pll_run_out       <= 1'b0;
      tx_run_out        <= 1'b0;
      rx_lane_mode_out  <= LANES_ONE;
      tx_lane_mode_out  <= LANES_ONE;
      clk_divide_out    <= 5'h00;
      clk_source_out    <= 2'h0;
      ref_use_one_out   <= 1'b0;
      bandwidth_out     <= 2'h0;
      vco_low_out       <= 1'b0;
      mult_quarters_out <= 7'h00;
      tx_amplitude_out  <= 4'h0;
      tx_rate_out       <= 2'h0;
    end
    else
    begin
      datapath_pd_out   <= pd_any;
      pll_run_out       <= pll_reg[PLL_EN_BIT] && !pd_any;
      tx_run_out        <= txrx_reg[TX_EN_BIT] && !pd_any;
      rx_lane_mode_out  <= ctrl_reg[RX_ONE_BIT] ? LANES_ONE :
                           (ctrl_reg[RX_SPLIT_BIT] ? LANES_FOUR : LANES_TWO);
      tx_lane_mode_out  <= ctrl_reg[TX_ONE_BIT] ? LANES_ONE :
                           (ctrl_reg[TX_MERGE_BIT] ? LANES_FOUR : LANES_TWO);
      clk_divide_out    <= divider_factor(ctrl_reg[DIV_LO +: 4]);
      clk_source_out    <= ctrl_reg[CLK_SRC_LO +: 2];
      // Pin high takes the choice away from software
      ref_use_one_out   <= ref_pin_in || ctrl_reg[REF_BIT];
      bandwidth_out     <= pll_reg[BW_LO +: 2];
      vco_low_out       <= pll_reg[VCO_BIT];
      mult_quarters_out <= mult_quarters(pll_reg[MULT_LO +: 4]);
      tx_amplitude_out  <= txrx_reg[SWING_LO +: 4];
      tx_rate_out       <= txrx_reg[RATE_LO +: 2];
    end
  end

  // Adjacent error run, saturating; a clean character breaks the run
  always_comb
  begin
    err_run_next = err_run_reg;
    if (char_valid_in)
      err_run_next = code_err_in ? ((err_run_reg == 2'h3) ? 2'h3 : err_run_reg + 2'h1) : 2'h0;
  end

  // Unsync request on every error once the run reaches the programmed length
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      err_run_reg        <= 2'h0;
      force_unsync_out   <= 1'b0;
      std_hysteresis_out <= 1'b1;
    end
    else
    begin
      err_run_reg        <= err_run_next;
      std_hysteresis_out <= (hyst == HYST_STD);
      force_unsync_out   <= char_valid_in && code_err_in && (hyst != HYST_STD) &&
                            (err_run_next >= hyst);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_pll_forced_off;
    pd_any |=> !pll_run_out;
  endproperty
  a_pll_forced_off: assert property (p_pll_forced_off) else $error("pll ran in power-down");

  property p_tx_forced_off;
    (pd_any || !txrx_reg[TX_EN_BIT]) |=> !tx_run_out;
  endproperty
  a_tx_forced_off: assert property (p_tx_forced_off) else $error("tx ran while off");

  property p_rx_lanes;
    rst_b_in && !ctrl_reg[RX_ONE_BIT] && ctrl_reg[RX_SPLIT_BIT] |=>
      rx_lane_mode_out == LANES_FOUR;
  endproperty
  a_rx_lanes: assert property (p_rx_lanes) else $error("rx split not one to four");

  property p_rx_one;
    ctrl_reg[RX_ONE_BIT] |=> rx_lane_mode_out == LANES_ONE;
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx one to one ignored");

  property p_tx_lanes;
    !ctrl_reg[TX_ONE_BIT] && !ctrl_reg[TX_MERGE_BIT] |=> tx_lane_mode_out == LANES_TWO;
  endproperty
  a_tx_lanes: assert property (p_tx_lanes) else $error("tx merge not two to one");

  property p_hyst_std;
    hyst == HYST_STD |=> !force_unsync_out && std_hysteresis_out;
  endproperty
  a_hyst_std: assert property (p_hyst_std) else $error("standard hysteresis overridden");

  property p_hyst_single;
    hyst == HYST_ONE && char_valid_in && code_err_in |=> force_unsync_out;
  endproperty
  a_hyst_single: assert property (p_hyst_single) else $error("single error did not unsync");

  property p_hyst_two;
    hyst == HYST_TWO && char_valid_in && code_err_in && err_run_reg == 2'h0 |=> !force_unsync_out;
  endproperty
  a_hyst_two: assert property (p_hyst_two) else $error("unsync on first of two errors");

endmodule : channel_regs
`default_nettype wire

/* File: verilog/serdes_channel_control_regs.sv */
// Management serial slave and the two channels' control register banks
`timescale 1ns/1ps
`default_nettype none
module serdes_channel_control_regs
  import serdes_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_b_in,
  // Management serial pins
  input  wire logic                      mdc_in,
  input  wire logic                      mdio_in,
  output logic                           mdio_out,
  output logic                           mdio_oe_b_out,
  input  wire logic [4:0]                port_addr_in,
  // Device-level pins
  input  wire logic                      global_write_in,
  input  wire logic [1:0]                channel_datapath_bit_a_pin_b_in,
  input  wire logic [1:0]                reference_source_pin_in,
  // Receive decoder events per channel
  input  wire logic [1:0]                char_valid_in,
  input  wire logic [1:0]                code_err_in,
  // Datapath controls per channel
  output logic [1:0]                     datapath_pd_out,
  output logic [1:0]                     pll_run_out,
  output logic [1:0]                     tx_run_out,
  output serdes_ctrl_pkg::lane_mode_t    rx_lane_mode_out [2],
  output serdes_ctrl_pkg::lane_mode_t    tx_lane_mode_out [2],
  output logic [4:0]                     clk_divide_out [2],
  output logic [1:0]                     clk_source_out [2],
  output logic [1:0]                     ref_use_one_out,
  output logic [1:0]                     bandwidth_out [2],
  output logic [1:0]                     vco_low_out,
  output logic [6:0]                     mult_quarters_out [2],
  output logic [3:0]                     tx_amplitude_out [2],
  output logic [1:0]                     tx_rate_out [2],
  output logic [1:0]                     std_hysteresis_out,
  output logic [1:0]                     force_unsync_out
);
  import serdes_ctrl_pkg::*;

  // Pin synchronisers: stage one feeds stage two only
  logic        mdc_s1_reg, mdc_s2_reg, mdc_d3_reg;
  logic        mdio_s1_reg, mdio_s2_reg;
  logic        gw_s1_reg, gw_s2_reg;
  logic [4:0]  pa_s1_reg, pa_s2_reg;
  logic [1:0]  pd_s1_reg, pd_s2_reg;
  logic [1:0]  ref_s1_reg, ref_s2_reg;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      {mdc_s1_reg, mdc_s2_reg, mdc_d3_reg} <= 3'h0;
      {mdio_s1_reg, mdio_s2_reg}           <= 2'h3;
      {gw_s1_reg, gw_s2_reg}               <= 2'h0;
      {pa_s1_reg, pa_s2_reg}               <= 10'h000;
      {pd_s1_reg, pd_s2_reg}               <= 4'hF;
      {ref_s1_reg, ref_s2_reg}             <= 4'h0;
    end
    else
    begin
      mdc_s1_reg  <= mdc_in;
      mdc_s2_reg  <= mdc_s1_reg;
      mdc_d3_reg  <= mdc_s2_reg;
      mdio_s1_reg <= mdio_in;
      mdio_s2_reg <= mdio_s1_reg;
      gw_s1_reg   <= global_write_in;
      gw_s2_reg   <= gw_s1_reg;
      pa_s1_reg   <= port_addr_in;
      pa_s2_reg   <= pa_s1_reg;
      pd_s1_reg   <= channel_datapath_bit_a_pin_b_in;
      pd_s2_reg   <= pd_s1_reg;
      ref_s1_reg  <= reference_source_pin_in;
      ref_s2_reg  <= ref_s1_reg;
    end
  end

  // Frame state
  mdio_state_t state_reg;
  logic [5:0]  pre_cnt_reg;
  logic [4:0]  bit_cnt_reg;
  logic [11:0] hdr_reg;
  logic [16:0] rd_shift_reg;
  logic [15:0] wr_shift_reg;
  logic        is_read_reg;
  logic        hit_reg;
  logic        chan_reg;
  logic [4:0]  addr_reg;
  logic        mdc_rise;
  logic [12:0] hdr_full;
  logic        hdr_hit;
  logic [1:0]  wr_en;
  logic [15:0] rd_data [2];

  // Edge taken from the synchronised copies, so MDC must stay slow versus the core clock
  assign mdc_rise = mdc_s2_reg && !mdc_d3_reg;
  assign hdr_full = {hdr_reg, mdio_s2_reg};
  assign hdr_hit  = hdr_full[12] && (hdr_full[9:6] == pa_s2_reg[4:1]) &&
                    (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);

  // Write strobes: addressed channel, or both under global write
  always_comb
  begin
    wr_en = 2'h0;
    if (state_reg == MD_DATA && mdc_rise && bit_cnt_reg == DATA_LAST && hit_reg && !is_read_reg)
    begin
      wr_en[0] = !chan_reg || gw_s2_reg;
      wr_en[1] = chan_reg || gw_s2_reg;
    end
  end

  // Frame sequencer: preamble, header, turnaround and data
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      state_reg    <= MD_PREAMBLE;
      pre_cnt_reg  <= 6'h00;
      bit_cnt_reg  <= 5'h00;
      hdr_reg      <= 12'h000;
      rd_shift_reg <= 17'h00000;
      wr_shift_reg <= 16'h0000;
      is_read_reg  <= 1'b0;
      hit_reg      <= 1'b0;
      chan_reg     <= 1'b0;
      addr_reg     <= 5'h00;
    end
    else if (mdc_rise)
    begin
      unique case (state_reg)
        MD_PREAMBLE:
        begin
          if (mdio_s2_reg)
            pre_cnt_reg <= (pre_cnt_reg == PREAMBLE_LEN) ? pre_cnt_reg : pre_cnt_reg + 6'h01;
          else
          begin
            pre_cnt_reg <= 6'h00;
            if (pre_cnt_reg == PREAMBLE_LEN)
            begin
              state_reg   <= MD_HEADER;
              bit_cnt_reg <= 5'h00;
            end
          end
        end
        MD_HEADER:
        begin
          hdr_reg     <= hdr_full[11:0];
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg[3:0] == HDR_LAST)
          begin
            state_reg    <= MD_DATA;
            bit_cnt_reg  <= 5'h00;
            hit_reg      <= hdr_hit;
            is_read_reg  <= (hdr_full[11:10] == OP_READ);
            chan_reg     <= hdr_full[5];
            addr_reg     <= hdr_full[4:0];
            rd_shift_reg <= {1'b0, rd_data[hdr_full[5]]};
          end
        end
        MD_DATA:
        begin
          bit_cnt_reg  <= bit_cnt_reg + 5'h01;
          wr_shift_reg <= {wr_shift_reg[14:0], mdio_s2_reg};
          if (bit_cnt_reg >= TA_DONE)
            rd_shift_reg <= {rd_shift_reg[15:0], 1'b0};
          if (bit_cnt_reg == DATA_LAST)
            state_reg <= MD_PREAMBLE;
        end
        default:
          state_reg <= MD_PREAMBLE;
      endcase
    end
  end

  // Pin drive: zero in the second turnaround bit, then sixteen data bits
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      mdio_out      <= 1'b1;
      mdio_oe_b_out <= 1'b1;
    end
    else if (mdc_rise)
    begin
      if (state_reg == MD_DATA && hit_reg && is_read_reg && bit_cnt_reg != DATA_LAST)
      begin
        mdio_oe_b_out <= 1'b0;
        mdio_out      <= (bit_cnt_reg == 5'h00) ? rd_shift_reg[16] : rd_shift_reg[15];
      end
      else
      begin
        mdio_oe_b_out <= 1'b1;
        mdio_out      <= 1'b1;
      end
    end
  end

  // Register banks, one per channel
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    channel_regs u_regs (
      .core_clk_in        (core_clk_in),
      .rst_b_in           (rst_b_in),
      .wr_en_in           (wr_en[ch]),
      .wr_addr_in         (addr_reg),
      .wr_data_in         ({wr_shift_reg[14:0], mdio_s2_reg}),
      .rd_addr_in         (hdr_full[4:0]),
      .rd_data_out        (rd_data[ch]),
      .datapath_bit_a_pin_b_in (pd_s2_reg[ch]),
      .ref_pin_in         (ref_s2_reg[ch]),
      .char_valid_in      (char_valid_in[ch]),
      .code_err_in        (code_err_in[ch]),
      .datapath_pd_out    (datapath_pd_out[ch]),
      .pll_run_out        (pll_run_out[ch]),
      .tx_run_out         (tx_run_out[ch]),
      .rx_lane_mode_out   (rx_lane_mode_out[ch]),
      .tx_lane_mode_out   (tx_lane_mode_out[ch]),
      .clk_divide_out     (clk_divide_out[ch]),
      .clk_source_out     (clk_source_out[ch]),
      .ref_use_one_out    (ref_use_one_out[ch]),
      .bandwidth_out      (bandwidth_out[ch]),
      .vco_low_out        (vco_low_out[ch]),
      .mult_quarters_out  (mult_quarters_out[ch]),
      .tx_amplitude_out   (tx_amplitude_out[ch]),
      .tx_rate_out        (tx_rate_out[ch]),
      .std_hysteresis_out (std_hysteresis_out[ch]),
      .force_unsync_out   (force_unsync_out[ch])
    );
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_global_both;
    wr_en[0] && gw_s2_reg |-> wr_en[1];
  endproperty
  a_global_both: assert property (p_global_both) else $error("global write missed a channel");

  property p_single_write;
    |wr_en && !gw_s2_reg |-> wr_en[chan_reg] && !wr_en[!chan_reg];
  endproperty
  a_single_write: assert property (p_single_write) else $error("write hit wrong channel");

  property p_mgmt_alive;
    |datapath_pd_out && mdc_rise && state_reg == MD_HEADER |=> state_reg != MD_HEADER ||
      bit_cnt_reg != 5'h00;
  endproperty
  a_mgmt_alive: assert property (p_mgmt_alive) else $error("frame stalled in power-down");

  property p_release_idle;
    state_reg == MD_PREAMBLE && $past(state_reg) == MD_PREAMBLE |-> mdio_oe_b_out;
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("pin driven outside a read");

endmodule : serdes_channel_control_regs
`default_nettype wire

/* File: test/mdio_station.sv */
// Management station model that clocks whole frames onto the serial pins
`timescale 1ns/1ps
`default_nettype none
module mdio_station
(
  // Clock and resolved data line
  input  wire logic core_clk_in,
  input  wire logic line_in,
  // Station side of the serial pins
  output logic      mdc_out,
  output logic      drive_en_out,
  output logic      bit_out
);
  // Idle: clock parked low, data released to the pull-up
  initial
  begin
    mdc_out = 1'b0;
    drive_en_out = 1'b0;
    bit_out = 1'b0;
  end

  // One frame, four core cycles per phase; read bits taken just before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFF_FFFF, 2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      @(posedge core_clk_in);
      mdc_out      <= 1'b0;
      drive_en_out <= !(op == 2'h2 && i < 18); // Let go from read turnaround through the data bits
      bit_out      <= f[i];
      repeat (3) @(posedge core_clk_in);
      @(negedge core_clk_in);
      if (i < 16)
        rd = {rd[14:0], line_in};
      @(posedge core_clk_in);
      mdc_out <= 1'b1;
      repeat (3) @(posedge core_clk_in);
    end
    @(posedge core_clk_in);
    mdc_out      <= 1'b0;
    drive_en_out <= 1'b0;
  endtask : frame
endmodule : mdio_station
`default_nettype wire

/* File: test/serdes_channel_control_regs_tb.sv */
// Self-checking bench for the channel control register block
`timescale 1ns/1ps
`default_nettype none
module serdes_channel_control_regs_tb;
  import serdes_ctrl_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, gw = 1'b0;
  logic [1:0]  pd_pin_b = 2'b11, ref_pin = 2'b00, cv = 2'b00, ce = 2'b00;
  logic        mdc, st_en, st_bit, mdio_out, oe_b, line;
  logic [1:0]  pd, pll_run, tx_run, ref_one, vco_low, std_h, unsync;
  lane_mode_t  rx_lane [2], tx_lane [2];
  logic [4:0]  div [2];
  logic [1:0]  src [2], bw [2], rate [2];
  logic [6:0]  mult [2];
  logic [3:0]  amp [2];
  logic [15:0] rd;
  int          err_count = 0, n_checks = 0;
  logic [15:0] pulses;
  // Rows as nibbles: global write, op, channel, register, data written or expected
  localparam logic [35:0] ROWS [14] = '{36'h0_2_0_01_0300, 36'h0_2_0_02_811D,
    36'h0_2_0_03_A444, 36'h0_2_1_02_811D, 36'h0_1_1_02_8246, 36'h0_2_1_02_8246,
    36'h0_2_0_02_811D, 36'h0_1_1_03_5344, 36'h0_2_1_03_5344, 36'h1_1_0_03_F644,
    36'h0_2_1_03_F644, 36'h0_2_0_03_F644, 36'h0_1_0_05_1234, 36'h0_2_0_05_0000};
  // Error pattern and expected pulse count per hysteresis code
  localparam logic [7:0] HYST [4] = '{8'hFC, 8'hA2, 8'hDA, 8'hDD};

  // Pull-up wins only when nobody drives
  assign line = !oe_b ? mdio_out : (st_en ? st_bit : 1'b1);

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  serdes_channel_control_regs serdes_channel_control_regs_i (.core_clk_in(clk),
    .rst_b_in(rst_b), .mdc_in(mdc), .mdio_in(line), .mdio_out(mdio_out),
    .mdio_oe_b_out(oe_b), .port_addr_in(5'h04), .global_write_in(gw),
    .channel_datapath_bit_a_pin_b_in(pd_pin_b), .reference_source_pin_in(ref_pin),
    .char_valid_in(cv), .code_err_in(ce), .datapath_pd_out(pd), .pll_run_out(pll_run),
    .tx_run_out(tx_run), .rx_lane_mode_out(rx_lane), .tx_lane_mode_out(tx_lane),
    .clk_divide_out(div), .clk_source_out(src), .ref_use_one_out(ref_one),
    .bandwidth_out(bw), .vco_low_out(vco_low), .mult_quarters_out(mult),
    .tx_amplitude_out(amp), .tx_rate_out(rate), .std_hysteresis_out(std_h),
    .force_unsync_out(unsync));

  mdio_station mdio_station_i (.core_clk_in(clk), .line_in(line), .mdc_out(mdc),
    .drive_en_out(st_en), .bit_out(st_bit));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Frame to this strap's channel, then let decoded outputs settle
  task automatic xfer(input logic [1:0] op, input logic ch, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [15:0] rd);
    mdio_station_i.frame(op, {4'h2, ch}, rg, wd, rd);
    repeat (4) @(posedge clk);
  endtask : xfer

  // Back-to-back characters on channel A, counting unsync pulses
  task automatic errs(input logic [7:0] row);
    pulses = 16'h0000;
    for (int i = 7; i >= -3; i--)
    begin
      @(posedge clk);
      pulses = pulses + 16'(unsync[0]);
      cv[0] <= (i >= 2);
      ce[0] <= (i >= 2) && row[i > 1 ? i : 2];
    end
    check("unsync_pulses", pulses, 16'(row[1:0]));
  endtask : errs

  // Watchdog well past the expected run of about 12k cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check("lanes", 16'({rx_lane[0], tx_lane[1]}), 16'({LANES_FOUR, LANES_FOUR}));
    check("div", 16'({div[0], rate[0]}), 16'h0004);
    check("mult", 16'({mult[1], amp[0]}), 16'h050A);
    check("run", 16'({pll_run, tx_run, std_h}), 16'h003F);
    // Stimulus keeps reserved fields at defaults; bandwidth 10 and low VCO range suit 8.25x
    foreach (ROWS[j])
    begin
      gw <= ROWS[j][32];
      xfer(ROWS[j][29:28], ROWS[j][24], ROWS[j][20:16], ROWS[j][15:0], rd);
      if (ROWS[j][29:28] == 2'h2)
        check("readback", rd, ROWS[j][15:0]);
    end
    check("pll_b", 16'({mult[1], bw[1], vco_low[1], pll_run[1]}), 16'h021A);
    check("tx_b", 16'({amp[1], rate[1], tx_run[1]}), 16'h007D);
    for (int k = 0; k < 4; k++)
    begin
      xfer(2'h1, 1'b0, 5'h01, 16'h21D6 | (16'(k) << 10), rd);
      check("std_hyst", 16'(std_h[0]), 16'(k == 0));
      errs(HYST[k]);
    end
    check("rx_one", 16'({rx_lane[0], tx_lane[0]}), 16'({LANES_ONE, LANES_FOUR}));
    check("clk_out", 16'({div[0], src[0], ref_one[0]}), 16'h0053);
    xfer(2'h1, 1'b0, 5'h01, 16'h8000, rd);
    xfer(2'h2, 1'b0, 5'h01, 16'h0000, rd);
    check("pd_read", rd, 16'h8000);
    check("pd", 16'({pd[0], pll_run[0], tx_run[0], rx_lane[0], tx_lane[0]}), 16'h0045);
    ref_pin <= 2'b01;
    pd_pin_b <= 2'b01;
    repeat (6) @(posedge clk);
    check("pins", 16'({ref_one[0], pd[1], tx_run[1]}), 16'h0006);
    mdio_station_i.frame(2'h1, 5'h06, 5'h01, 16'hFFFF, rd);
    xfer(2'h2, 1'b0, 5'h01, 16'h0000, rd);
    check("bad_phy", rd, 16'h8000);
    // Mid-run reset must bring written registers back to defaults
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(2'h2, 1'b1, 5'h03, 16'h0000, rd);
    check("reset_read", rd, RST_TXRX);
    complete_run();
  end
endmodule : serdes_channel_control_regs_tb
`default_nettype wire
